// *** hdl/obcd_pkg.sv ***
// package: option byte layout, defaults, codes and timing for the option byte decoder
package obcd_pkg;
   // option byte 0 fields
   localparam int B0_HALT_RESET_POS = 7;
   localparam int B0_WDG_TYPE_POS   = 6;
   localparam int B0_CLK_GUARD_POS  = 5;
   localparam int B0_SUPPLY_HI_POS  = 4;
   localparam int B0_SUPPLY_LO_POS  = 3;
   localparam int B0_PKG_LO_POS     = 1;
   localparam int B0_READOUT_POS    = 0;
   // option byte 1 fields
   localparam int B1_PKG_HI_POS     = 7;
   localparam int B1_RST_DELAY_POS  = 6;
   localparam int B1_OSC_KIND_HI    = 5;
   localparam int B1_OSC_KIND_LO    = 4;
   localparam int B1_BAND_HI        = 3;
   localparam int B1_BAND_LO        = 1;
   localparam int B1_DOUBLER_POS    = 0;
   // erased flash and shipped defaults
   localparam logic [7:0] ERASED_BYTE   = 8'h00FF;
   localparam logic [7:0] SHIP_BYTE0    = 8'h00E7;
   localparam logic [7:0] SHIP_BYTE1    = 8'h00EF;
   // reset delay lengths in cpu cycles
   localparam int RST_DELAY_LONG  = 4096;
   localparam int RST_DELAY_SHORT = 256;
   // local programming-port addresses
   localparam logic [0:0] ADDR_BYTE0 = 1'h0;
   localparam logic [0:0] ADDR_BYTE1 = 1'h1;
   // user memory size in words for the mass erase
   localparam int USER_WORDS = 16;
   typedef enum logic [1:0]
   {
      OSC_RESONATOR = 2'h0,
      OSC_EXT_RC    = 2'h1,
      OSC_INT_RC    = 2'h2,
      OSC_EXTERNAL  = 2'h3
   } obcd_osc_t;
   typedef enum logic [1:0]
   {
      SUP_HIGH  = 2'h0,
      SUP_NU_35 = 2'h1,
      SUP_NU_30 = 2'h2,
      SUP_OFF   = 2'h3
   } obcd_supply_t;
   typedef enum logic [1:0]
   {
      PKG_OTHER = 2'h0,
      PKG_64    = 2'h2,
      PKG_80    = 2'h3
   } obcd_pkg_t;
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_WIPE  = 2'b01,
      ST_CLEAR = 2'b10
   } obcd_state_t;
endpackage

// *** hdl/obcd_store.sv ***
// two-word option byte store with registered read data
module obcd_store
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic             wr_en,
   input  wire logic [0:0]       wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [0:0]       rd_addr,
   output logic [WIDTH-1:0]      rd_data,
   output logic [WIDTH-1:0]      word0,
   output logic [WIDTH-1:0]      word1
);
   import obcd_pkg::*;
   ////////////////////////////////////////////////////////////////
   // storage, non-volatile model: shipped values after power-up
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word0 <= WIDTH'(SHIP_BYTE0);
         word1 <= WIDTH'(SHIP_BYTE1);
      end
      else if (clk_en && wr_en)
      begin
         if (wr_addr == ADDR_BYTE0)
            word0 <= wr_data;
         else
            word1 <= wr_data;
      end
   end
   ////////////////////////////////////////////////////////////////
   // registered read
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= '0;
      else if (clk_en)
         rd_data <= (rd_addr == ADDR_BYTE0) ? word0 : word1;
   end
endmodule // obcd_store

// *** hdl/obcd_decoder.sv ***
// option byte decoder: programming port, erase sequence and latched configuration
//
// How it works
// - byte0 bit7: halt under watchdog resets
// - byte0 bit6: hardware or software watchdog
// - byte0 bit5 low enables clock guard
// - byte0 bits4:3 supply detector level select
// - byte1 bit7, byte0 bit1 select package
// - unbonded pads stay pulled-up inputs
// - byte0 bit0 low locks memory readout
// - locked erase wipes user memory first
// - byte1 bit6 picks 4096 or 256 cycles
// - clock guard runs reset delay on backup oscillator
// - byte1 bits5:4 select main clock source
// - byte1 bits3:1 select frequency band
// - byte1 bit0 low enables clock doubler
// - bytes reachable only in programming mode
// - erased flash reads all ones
module obcd_decoder
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   input  wire logic                 prog_mode,
   input  wire logic                 test_mode,
   input  wire logic [0:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   input  wire logic                 erase_stb,
   input  wire logic                 halt_entry,
   input  wire logic                 watchdog_active,
   output logic [7:0]                rdata,
   output logic                      erase_busy,
   output logic                      user_wipe_stb,
   output logic [$clog2(obcd_pkg::USER_WORDS)-1:0] user_wipe_addr,
   output logic                      halt_reset_select,
   output logic                      halt_reset_req,
   output logic                      watchdog_type_select,
   output logic                      watchdog_hw_enable,
   output logic                      clock_guard_enable,
   output obcd_pkg::obcd_supply_t    supply_detect_level,
   output logic                      low_supply_detector,
   output logic                      aux_supply_detector,
   output logic                      package_sel_hi,
   output logic                      package_sel_lo,
   output obcd_pkg::obcd_pkg_t       package_code,
   output logic                      unbonded_pullup,
   output logic                      readout_lock,
   output logic                      user_access_block,
   output logic                      reset_delay_select,
   output logic [12:0]               reset_delay_cycles,
   output logic                      delay_on_backup_osc,
   output obcd_pkg::obcd_osc_t       osc_source_kind,
   output logic [2:0]                osc_freq_band,
   output logic                      doubler_enable,
   output logic                      doubler_misuse
);
   import obcd_pkg::*;

   localparam int WA = $clog2(USER_WORDS);

   obcd_state_t    state;
   logic [WA-1:0]  wipe_cnt;
   logic           st_wr;
   logic [0:0]     st_addr;
   logic [7:0]     st_wdata;
   logic [7:0]     byte0;
   logic [7:0]     byte1;
   logic [7:0]     cfg0;
   logic [7:0]     cfg1;
   logic           captured;
   logic           prog_s1;
   logic           prog_s2;
   logic           test_s1;
   logic           test_s2;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prog_s1 <= 1'b0;
         prog_s2 <= 1'b0;
         test_s1 <= 1'b0;
         test_s2 <= 1'b0;
      end
      else if (clk_en)
      begin
         prog_s1 <= prog_mode;
         prog_s2 <= prog_s1;
         test_s1 <= test_mode;
         test_s2 <= test_s1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // store port muxing: tool writes or erase clears to ones
   always_comb
   begin
      st_wr    = 1'b0;
      st_addr  = addr;
      st_wdata = wdata;
      if (state == ST_CLEAR)
      begin
         st_wr    = 1'b1;
         st_addr  = wipe_cnt[0:0];
         st_wdata = ERASED_BYTE;
      end
      else if (state == ST_IDLE && prog_s2 && wr_stb)
         st_wr = 1'b1;
   end

   obcd_store #(.WIDTH(8)) u_store
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .wr_en   (st_wr),
      .wr_addr (st_addr),
      .wr_data (st_wdata),
      .rd_addr (addr),
      .rd_data (),
      .word0   (byte0),
      .word1   (byte1)
   );

   ////////////////////////////////////////////////////////////////
   // erase sequence: user memory first when locked
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state    <= ST_IDLE;
         wipe_cnt <= '0;
      end
      else if (clk_en)
      begin
         case (state)
            ST_IDLE:
            begin
               wipe_cnt <= '0;
               if (prog_s2 && erase_stb)
                  state <= byte0[B0_READOUT_POS] ? ST_CLEAR : ST_WIPE;
            end
            ST_WIPE:
            begin
               wipe_cnt <= wipe_cnt + 1'b1;
               if (wipe_cnt == WA'(USER_WORDS - 1))
                  state <= ST_CLEAR;
            end
            ST_CLEAR:
            begin
               wipe_cnt <= wipe_cnt + 1'b1;
               if (wipe_cnt[0])
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         erase_busy     <= 1'b0;
         user_wipe_stb  <= 1'b0;
         user_wipe_addr <= '0;
      end
      else if (clk_en)
      begin
         erase_busy     <= (state != ST_IDLE) || (prog_s2 && erase_stb);
         user_wipe_stb  <= (state == ST_WIPE);
         user_wipe_addr <= wipe_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read data: one cycle after the strobe, zero outside programming mode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (clk_en)
      begin
         if (rd_stb && prog_s2 && (state == ST_IDLE))
            rdata <= (addr == ADDR_BYTE0) ? byte0 : byte1;
         else
            rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////
   // capture once after reset release, hold until next reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         captured <= 1'b0;
         cfg0     <= ERASED_BYTE;
         cfg1     <= ERASED_BYTE;
      end
      else if (clk_en && !captured)
      begin
         captured <= 1'b1;
         cfg0     <= byte0;
         cfg1     <= byte1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // field decode helpers
   function automatic logic supply_on(input logic [7:0] b0);
      return b0[B0_SUPPLY_HI_POS:B0_SUPPLY_LO_POS] != 2'(SUP_OFF);
   endfunction

   function automatic logic doubler_bad(input logic [7:0] b1);
      logic [1:0] kind;
      logic [2:0] band;
      kind = b1[B1_OSC_KIND_HI:B1_OSC_KIND_LO];
      band = b1[B1_BAND_HI:B1_BAND_LO];
      return !b1[B1_DOUBLER_POS] && (band != 3'h1 || kind == 2'(OSC_INT_RC));
   endfunction

   ////////////////////////////////////////////////////////////////
   // watchdog and halt controls
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         halt_reset_select    <= 1'b1;
         halt_reset_req       <= 1'b0;
         watchdog_type_select <= 1'b1;
         watchdog_hw_enable   <= 1'b0;
      end
      else if (clk_en)
      begin
         halt_reset_select    <= cfg0[B0_HALT_RESET_POS];
         halt_reset_req       <= cfg0[B0_HALT_RESET_POS] && halt_entry && watchdog_active;
         watchdog_type_select <= cfg0[B0_WDG_TYPE_POS];
         watchdog_hw_enable   <= !cfg0[B0_WDG_TYPE_POS];
      end
   end

   ////////////////////////////////////////////////////////////////
   // clock source, guard, doubler and reset delay controls
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clock_guard_enable   <= 1'b0;
         delay_on_backup_osc  <= 1'b0;
         reset_delay_select   <= 1'b1;
         reset_delay_cycles   <= 13'(RST_DELAY_SHORT);
         osc_source_kind      <= OSC_EXTERNAL;
         osc_freq_band        <= 3'h7;
         doubler_enable       <= 1'b0;
         doubler_misuse       <= 1'b0;
      end
      else if (clk_en)
      begin
         clock_guard_enable   <= !cfg0[B0_CLK_GUARD_POS];
         delay_on_backup_osc  <= !cfg0[B0_CLK_GUARD_POS];
         reset_delay_select   <= cfg1[B1_RST_DELAY_POS];
         reset_delay_cycles   <= cfg1[B1_RST_DELAY_POS] ? 13'(RST_DELAY_SHORT) : 13'(RST_DELAY_LONG);
         osc_source_kind      <= obcd_osc_t'(cfg1[B1_OSC_KIND_HI:B1_OSC_KIND_LO]);
         osc_freq_band        <= cfg1[B1_BAND_HI:B1_BAND_LO];
         doubler_enable       <= !cfg1[B1_DOUBLER_POS];
         doubler_misuse       <= doubler_bad(cfg1);
      end
   end

   ////////////////////////////////////////////////////////////////
   // supply, package and protection controls
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_detect_level  <= SUP_OFF;
         low_supply_detector  <= 1'b0;
         aux_supply_detector  <= 1'b0;
         package_sel_hi       <= 1'b1;
         package_sel_lo       <= 1'b1;
         package_code         <= PKG_80;
         unbonded_pullup      <= 1'b1;
         readout_lock         <= 1'b0;
         user_access_block    <= 1'b0;
      end
      else if (clk_en)
      begin
         supply_detect_level  <= obcd_supply_t'(cfg0[B0_SUPPLY_HI_POS:B0_SUPPLY_LO_POS]);
         low_supply_detector  <= supply_on(cfg0);
         aux_supply_detector  <= supply_on(cfg0);
         package_sel_hi       <= cfg1[B1_PKG_HI_POS];
         package_sel_lo       <= cfg0[B0_PKG_LO_POS];
         package_code         <= obcd_pkg_t'({cfg1[B1_PKG_HI_POS], cfg0[B0_PKG_LO_POS]});
         unbonded_pullup      <= 1'b1;
         readout_lock         <= !cfg0[B0_READOUT_POS];
         user_access_block    <= !cfg0[B0_READOUT_POS] && (prog_s2 || test_s2);
      end
   end
endmodule // obcd_decoder

// *** tb/obcd_decoder_assertions.sv ***
// checker: concurrent assertions on the option byte decoder ports
module obcd_decoder_assertions
(
   input wire logic                 clk_sys,
   input wire logic                 rst_n,
   input wire logic                 prog_mode,
   input wire logic                 rd_stb,
   input wire logic [7:0]           rdata,
   input wire logic                 erase_busy,
   input wire logic                 user_wipe_stb,
   input wire logic                 halt_entry,
   input wire logic                 watchdog_active,
   input wire logic                 halt_reset_select,
   input wire logic                 halt_reset_req,
   input wire logic                 clock_guard_enable,
   input wire logic                 delay_on_backup_osc,
   input wire logic                 readout_lock,
   input wire logic                 user_access_block,
   input wire logic                 reset_delay_select,
   input wire logic [12:0]          reset_delay_cycles,
   input wire obcd_pkg::obcd_osc_t  osc_source_kind,
   input wire logic [2:0]           osc_freq_band,
   input wire logic                 doubler_enable,
   input wire logic                 doubler_misuse
);
   timeunit 1ns;
   timeprecision 1ps;
   import obcd_pkg::*;
   logic [1:0] cnt;
   wire        settled    = (cnt == 2'h3);
   wire        halt_cause = halt_reset_select & halt_entry & watchdog_active;
   wire        misuse     = doubler_enable && (osc_freq_band != 3'h1 || osc_source_kind == OSC_INT_RC);
   // edges since reset release, saturating
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         cnt <= 2'h0;
      else if (cnt != 2'h3)
         cnt <= cnt + 2'h1;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_halt_request: assert property (cnt != 2'h0 |-> halt_reset_req == $past(halt_cause))
      else $error("halt reset request wrong");
   a_guard_backup: assert property (settled |-> delay_on_backup_osc == clock_guard_enable)
      else $error("backup oscillator start differs from guard");
   a_delay_length: assert property (settled |-> reset_delay_cycles == (reset_delay_select ? 13'h0100 : 13'h1000))
      else $error("reset delay length wrong");
   a_lock_block: assert property (!readout_lock |-> !user_access_block)
      else $error("access blocked while unlocked");
   a_config_hold: assert property (settled |-> $stable({halt_reset_select, readout_lock, reset_delay_cycles, osc_freq_band}))
      else $error("decoded setting changed");
   a_read_idle: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("read data without read");
   a_read_refused: assert property (!prog_mode [*3] ##0 rd_stb |=> rdata == 8'h00)
      else $error("read answered outside programming");
   a_wipe_busy: assert property (user_wipe_stb |-> erase_busy)
      else $error("wipe pulse while idle");
   a_doubler_flag: assert property (settled |-> doubler_misuse == misuse)
      else $error("doubler misuse flag wrong");
   c_wipe: cover property (user_wipe_stb ##1 user_wipe_stb);
   c_halt: cover property (halt_reset_req);
   c_read: cover property (rd_stb ##1 rdata != 8'h00);
endmodule // obcd_decoder_assertions

// *** tb/obcd_tool_model.sv ***
// programming tool model: drives the option byte port
module obcd_tool_model
(
   input  wire logic       clk_sys,
   output logic [0:0]      addr,
   output logic [7:0]      wdata,
   output logic            wr_stb,
   output logic            rd_stb,
   output logic            erase_stb,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      addr      = 1'h0;
      wdata     = 8'h00;
      wr_stb    = 1'b0;
      rd_stb    = 1'b0;
      erase_stb = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // safe byte1 settings only
   function automatic logic [7:0] legal_b1(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (r[5:4] == 2'h0)
         r[6] = 1'b0;
      if (!r[0] && (r[5:4] == 2'h2 || r[3:1] != 3'h1))
         r[0] = 1'b1;
      return r;
   endfunction
   task automatic wr(input logic [0:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      wdata  <= ~d;
   endtask
   task automatic rd(input logic [0:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask
   task automatic erase();
      @(posedge clk_sys);
      erase_stb <= 1'b1;
      @(posedge clk_sys);
      erase_stb <= 1'b0;
   endtask
endmodule // obcd_tool_model

// *** tb/tb_top.sv ***
// top testbench: option byte decoder, tool model and checker bind
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import obcd_pkg::*;
   logic         clk_sys, rst_n, prog_mode, test_mode, halt_entry, watchdog_active, settled, exp_req;
   logic [0:0]   addr, a;
   logic [7:0]   wdata, rdata, v;
   logic [7:0]   m [2];
   logic         wr_stb, rd_stb, erase_stb, erase_busy, user_wipe_stb, halt_reset_select, halt_reset_req;
   logic         watchdog_type_select, watchdog_hw_enable, clock_guard_enable, low_supply_detector;
   logic         aux_supply_detector, package_sel_hi, package_sel_lo, unbonded_pullup, readout_lock;
   logic         user_access_block, reset_delay_select, delay_on_backup_osc, doubler_enable, doubler_misuse;
   logic [3:0]   user_wipe_addr;
   logic [12:0]  reset_delay_cycles;
   logic [2:0]   osc_freq_band;
   obcd_supply_t supply_detect_level;
   obcd_pkg_t    package_code;
   obcd_osc_t    osc_source_kind;
   int           seed = 32'hda97;
   int           n_fail = 0;
   int           comparisons = 0;
   obcd_decoder i_obcd_decoder (.clk_sys, .rst_n, .clk_en(1'b1), .prog_mode, .test_mode, .addr, .wdata, .wr_stb,
      .rd_stb, .erase_stb, .halt_entry, .watchdog_active, .rdata, .erase_busy, .user_wipe_stb, .user_wipe_addr,
      .halt_reset_select, .halt_reset_req, .watchdog_type_select, .watchdog_hw_enable, .clock_guard_enable,
      .supply_detect_level, .low_supply_detector, .aux_supply_detector, .package_sel_hi, .package_sel_lo,
      .package_code, .unbonded_pullup, .readout_lock, .user_access_block, .reset_delay_select,
      .reset_delay_cycles, .delay_on_backup_osc, .osc_source_kind, .osc_freq_band, .doubler_enable,
      .doubler_misuse);
   obcd_tool_model i_obcd_tool_model (.clk_sys, .addr, .wdata, .wr_stb, .rd_stb, .erase_stb, .rdata);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic do_reset();
      settled = 1'b0;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      m[0] = 8'hE7;
      m[1] = 8'hEF;
      settled = 1'b1;
   endtask
   task automatic rd_both();
      logic [7:0] d;
      for (int i = 0; i < 2; i++)
      begin
         i_obcd_tool_model.rd(1'(i), d);
         chk(d, m[i]);
      end
   endtask
   task automatic check_decode();
      chk(halt_reset_select, 1'b1);
      chk(watchdog_hw_enable, 1'b0);
      chk(clock_guard_enable, 1'b0);
      chk(supply_detect_level, 2'h0);
      chk(low_supply_detector, 1'b1);
      chk(package_code, 2'h3);
      chk(unbonded_pullup, 1'b1);
      chk(user_access_block, 1'b0);
      chk(reset_delay_cycles, 13'h0100);
      chk(delay_on_backup_osc, 1'b0);
      chk(osc_source_kind, OSC_INT_RC);
      chk(osc_freq_band, 3'h7);
      chk(doubler_enable, 1'b0);
   endtask
   task automatic erase_run(input logic [4:0] wipes);
      logic [4:0] n;
      int         k;
      n = 5'h00;
      k = 0;
      i_obcd_tool_model.erase();
      do
      begin
         @(negedge clk_sys);
         if (user_wipe_stb === 1'b1)
         begin
            chk(user_wipe_addr, n);
            n = n + 5'h01;
         end
         k++;
      end
      while (erase_busy === 1'b1 && k < 60);
      if (k >= 60)
      begin
         n_fail++;
         close_out();
      end
      chk(n, wipes);
      m[0] = 8'hFF;
      m[1] = 8'hFF;
      rd_both();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      exp_req         <= halt_entry & watchdog_active;
      halt_entry      <= 1'($random(seed));
      watchdog_active <= 1'($random(seed));
      test_mode       <= 1'($random(seed));
   end
   always @(negedge clk_sys)
      if (settled)
         chk(halt_reset_req, exp_req);
   initial
   begin
      prog_mode = 1'b1;
      test_mode = 1'b0;
      halt_entry = 1'b0;
      watchdog_active = 1'b0;
      rst_n = 1'b0;
      do_reset();
      check_decode();
      rd_both();
      repeat (6)
      begin
         a = 1'($random(seed));
         v = 8'($random(seed));
         v = a ? i_obcd_tool_model.legal_b1(v) : v;
         i_obcd_tool_model.wr(a, v);
         m[a] = v;
         rd_both();
      end
      check_decode();
      prog_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      i_obcd_tool_model.wr(1'h1, 8'h5A);
      i_obcd_tool_model.rd(1'h0, v);
      chk(v, 8'h00);
      prog_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_both();
      i_obcd_tool_model.wr(1'h0, 8'($random(seed)) | 8'h01);
      erase_run(5'h00);
      i_obcd_tool_model.wr(1'h0, 8'($random(seed)) & 8'hFE);
      erase_run(5'h10);
      do_reset();
      rd_both();
      check_decode();
      close_out();
   end
endmodule // tb_top
bind obcd_decoder obcd_decoder_assertions i_chk (.clk_sys, .rst_n, .prog_mode, .rd_stb, .rdata, .erase_busy,
   .user_wipe_stb, .halt_entry, .watchdog_active, .halt_reset_select, .halt_reset_req, .clock_guard_enable,
   .delay_on_backup_osc, .readout_lock, .user_access_block, .reset_delay_select, .reset_delay_cycles,
   .osc_source_kind, .osc_freq_band, .doubler_enable, .doubler_misuse);
